// >>> dsg_pkg.sv
// dsg_pkg: constants and types for the dma start gating block
// assumes a single 100 MHz pci clock domain
package dsg_pkg;

  // ------------------------------------------------------------
  // widths and reset values
  // ------------------------------------------------------------
  localparam int unsigned BAR_W        = 3;
  localparam logic [2:0]  BAR_RST      = 3'h0;
  localparam logic        REQN_RST     = 1'b1;
  localparam logic        HALT_ONE_RST = 1'b0;
  localparam logic        DIR_RST      = 1'b0;

  // ------------------------------------------------------------
  // master sequencer states
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    DSG_IDLE = 4'h1,
    DSG_WAIT = 4'h2,
    DSG_REQ  = 4'h4,
    DSG_XFER = 4'h8
  } dsg_state_e;

endpackage

// >>> dsg_start_gate.sv
// dsg_start_gate: holds off dma launch while the backend is busy,
// raises the pci request one cycle after busy drops.
// assumes busy, halt and arbiter inputs are synchronous to ref_clk.
//
// Overview of operation
// - read busy blocks any dma read start
// - write busy blocks any dma write start
// - output shows bar space dma uses
// - request asserted cycle after busy clears
// - busy release starts, halt or last word stops
// - halt held: launch, end after one word
`timescale 1ns/1ps
`default_nettype none

module dsg_start_gate
  import dsg_pkg::*;
(
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  // dma programming side
  input  wire logic             dma_pending,
  input  wire logic             dma_is_write,
  input  wire logic [BAR_W-1:0] dma_bar,
  // backend gating
  input  wire logic             rd_busy,
  input  wire logic             wr_busy,
  input  wire logic             master_halt,
  // pci arbiter and data path
  input  wire logic             gnt_n,
  input  wire logic             word_done,
  input  wire logic             xfer_last,
  // status outputs
  output logic                  req_n,
  output logic                  mast_active,
  output logic                  halt_after_one,
  output logic                  xfer_end,
  output logic [BAR_W-1:0]      dma_bar_sel
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  dsg_state_e       state_q;
  dsg_state_e       state_d;
  logic             req_n_q;
  logic             req_n_d;
  logic             one_q;
  logic             one_d;
  logic             dir_q;
  logic             dir_d;
  logic [BAR_W-1:0] bar_q;
  logic [BAR_W-1:0] bar_d;
  logic             busy_sel;
  logic             take_dma;
  logic             launch;
  logic             granted;
  logic             end_now;

  // ------------------------------------------------------------
  // launch decisions
  // ------------------------------------------------------------
  // busy is read straight off the pin at the deciding edge; one more
  // sampling stage would push the request a cycle too late
  always_comb
  begin
    busy_sel = dir_q ? wr_busy : rd_busy;
    take_dma = (state_q == DSG_IDLE) && dma_pending;
    launch   = (state_q == DSG_WAIT) && !busy_sel;
    granted  = (state_q == DSG_REQ) && !gnt_n;
    // halt at any word, or latched at launch, ends the cycle
    end_now  = (state_q == DSG_XFER) && word_done
               && (one_q || xfer_last || master_halt);
  end

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      DSG_IDLE:
      begin
        if (take_dma)
        begin
          state_d = DSG_WAIT;
        end
      end
      DSG_WAIT:
      begin
        if (launch)
        begin
          state_d = DSG_REQ;
        end
      end
      DSG_REQ:
      begin
        if (granted)
        begin
          state_d = DSG_XFER;
        end
      end
      DSG_XFER:
      begin
        if (end_now)
        begin
          state_d = DSG_IDLE;
        end
      end
      default:
      begin
        state_d = DSG_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q <= DSG_IDLE;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // ------------------------------------------------------------
  // bus request
  // ------------------------------------------------------------
  // request only ever stands in the request state, so a stray state
  // code cannot leave the bus requested
  always_comb
  begin
    req_n_d = req_n_q;
    if (launch)
    begin
      req_n_d = 1'b0;
    end
    else if (granted || (state_q != DSG_REQ))
    begin
      req_n_d = REQN_RST;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      req_n_q <= REQN_RST;
    end
    else
    begin
      req_n_q <= req_n_d;
    end
  end

  // ------------------------------------------------------------
  // direction and bar capture
  // ------------------------------------------------------------
  always_comb
  begin
    dir_d = dir_q;
    bar_d = bar_q;
    if (take_dma)
    begin
      dir_d = dma_is_write;
      bar_d = dma_bar;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      dir_q <= DIR_RST;
      bar_q <= BAR_RST;
    end
    else
    begin
      dir_q <= dir_d;
      bar_q <= bar_d;
    end
  end

  // ------------------------------------------------------------
  // single word after halt
  // ------------------------------------------------------------
  always_comb
  begin
    one_d = one_q;
    if (launch)
    begin
      one_d = master_halt;
    end
    else if (end_now)
    begin
      one_d = HALT_ONE_RST;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      one_q <= HALT_ONE_RST;
    end
    else
    begin
      one_q <= one_d;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign req_n          = req_n_q;
  assign mast_active    = (state_q == DSG_XFER);
  assign halt_after_one = one_q;
  assign xfer_end       = end_now;
  assign dma_bar_sel    = bar_q;

endmodule // dsg_start_gate

`default_nettype wire

// >>> dsg_far_model.sv
// far side: arbiter grants, backend moves one word a cycle
`timescale 1ns/1ps
`default_nettype none
module dsg_far_model (
  input  wire logic ref_clk, sys_rst, req_n, mast_active,
  output logic      gnt_n, word_done, xfer_last);
  logic [1:0] n_q;
  always_ff @(posedge ref_clk or posedge sys_rst)
    if (sys_rst) {gnt_n, n_q} <= 3'h4;
    else {gnt_n, n_q} <= {req_n, mast_active ? n_q + 2'h1 : 2'h0};
  assign word_done = mast_active;
  assign xfer_last = n_q == 2'h3;
endmodule // dsg_far_model
`default_nettype wire

// >>> dsg_props.sv
// start gating checks, bound onto dsg_start_gate
`timescale 1ns/1ps
`default_nettype none
module dsg_props (
  input wire logic ref_clk, sys_rst, dma_is_write, rd_busy, wr_busy,
  input wire logic gnt_n, word_done, req_n, mast_active, halt_after_one,
  input wire logic xfer_end,
  input wire logic [2:0] dma_bar_sel);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  chk_rd_gate: assert property ($fell(req_n) && !dma_is_write |->
    !$past(rd_busy)) else $error("read start while busy");
  chk_wr_gate: assert property ($fell(req_n) && dma_is_write |->
    !$past(wr_busy)) else $error("write start while busy");
  chk_req_grant: assert property (!req_n && !gnt_n |=>
    mast_active && req_n) else $error("no launch at grant");
  chk_bar_hold: assert property (mast_active |->
    $stable(dma_bar_sel)) else $error("bar moved in transfer");
  chk_end_word: assert property (xfer_end |->
    word_done ##1 !mast_active) else $error("bad transfer end");
  chk_halt_one: assert property (halt_after_one && word_done |->
    xfer_end) else $error("halted cycle ran on");
endmodule // dsg_props
bind dsg_start_gate dsg_props chk_u (.*);
`default_nettype wire

// >>> dsg_start_gate_tb.sv
// gated read and write launches, with and without halt
`timescale 1ns/1ps
`default_nettype none
module dsg_start_gate_tb;
  logic ref_clk = 0, sys_rst = 1, dma_pending = 0, dma_is_write = 0;
  logic rd_busy = 1, wr_busy = 1, master_halt = 0;
  logic [2:0] dma_bar = 3'h0;
  wire logic gnt_n, word_done, xfer_last, req_n, mast_active;
  wire logic halt_after_one, xfer_end;
  wire logic [2:0] dma_bar_sel;
  int err_total = 0, n_checks = 0, cyc = 0;
  initial forever #5 ref_clk = ~ref_clk;
  dsg_start_gate dut_u (.*);
  dsg_far_model far_u (.*);
  task automatic chk(string nm, logic [7:0] s, logic [7:0] e);
    n_checks++;
    if (s !== e)
    begin
      err_total++;
      $display("ERROR %s exp %0h seen %0h", nm, e, s);
    end
  endtask
  task automatic run(logic w, logic [2:0] b, logic h, string nm);
    int n;
    dma_pending <= 1; dma_is_write <= w; dma_bar <= b; master_halt <= h;
    repeat (6)
    begin
      @(posedge ref_clk); #1 chk("req_n", 8'(req_n), 8'h1);
    end
    @(posedge ref_clk);
    rd_busy <= w;
    wr_busy <= !w;
    n = 0;
    do begin @(posedge ref_clk); #1 n++; end while (req_n && n < 9);
    chk("latency", 8'(n), 8'h1);
    n = 0;
    do begin
      @(posedge ref_clk); dma_pending <= 0; #1 n += word_done;
    end while (!xfer_end && n < 9);
    chk("words", 8'(n), h ? 8'h1 : 8'h4);
    chk("bar", 8'(dma_bar_sel), 8'(b));
    @(posedge ref_clk); rd_busy <= 1; wr_busy <= 1;
    $display("%s done", nm);
  endtask
  task close_out;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge ref_clk) if (++cyc == 2000)
  begin
    err_total++;
    close_out;
  end
  initial
  begin
    repeat (6) @(posedge ref_clk);
    sys_rst <= 0;
    run(0, 3'h5, 0, "read"); run(1, 3'h2, 0, "write");
    run(0, 3'h7, 1, "halt read"); run(1, 3'h0, 1, "halt write");
    close_out;
  end
endmodule // dsg_start_gate_tb
`default_nettype wire
